// ---- tune_regs_pkg.sv ----
// constants for the antenna tuning and display register group
`default_nettype none
package tune_regs_pkg;
  localparam int unsigned ADDR_W    = 6;
  localparam int unsigned DATA_W    = 8;
  localparam int unsigned TRIM_W    = 4;
  localparam int unsigned SPEED_W   = 4;
  localparam int unsigned SPLIT_W   = 3;

  // register offsets
  localparam logic [ADDR_W-1:0] SPEED_DISPLAY_ADDR  = 6'h1f;
  localparam logic [ADDR_W-1:0] CONVERTER_OUT_ADDR  = 6'h20;
  localparam logic [ADDR_W-1:0] TUNE_CONTROL_ADDR   = 6'h21;
  localparam logic [ADDR_W-1:0] TARGET_PHASE_ADDR   = 6'h22;
  localparam logic [ADDR_W-1:0] RESULT_DISPLAY_ADDR = 6'h23;

  // field positions
  localparam int unsigned SPEED_LSB       = 4;
  localparam int unsigned SOURCE_BIT      = 7;
  localparam int unsigned MANUAL_LSB      = 3;
  localparam int unsigned RESULT_LSB      = 4;
  localparam int unsigned CALIB_ERR_BIT   = 3;

  // reset values
  localparam logic [DATA_W-1:0]  DISPLAY_RESET      = 8'h00;
  localparam logic [DATA_W-1:0]  TARGET_PHASE_RESET = 8'h80;
  localparam logic [TRIM_W-1:0]  TRIM_RESET         = 4'h0;
  localparam logic [SPEED_W-1:0] SPEED_RESET        = 4'h0;
  localparam logic [SPLIT_W-1:0] NO_SPLIT_BITS      = 3'h0;
  localparam logic               SOURCE_AUTO        = 1'b0;
  localparam logic               SOURCE_MANUAL      = 1'b1;
endpackage
`default_nettype wire

// ---- calib_link_if.sv ----
// calibration result carried from the result store to the switch driver
`timescale 1ns/1ns
`default_nettype none
interface calib_link_if;
  logic [tune_regs_pkg::TRIM_W-1:0] trim_result;
  logic                             calib_error;

  modport store (output trim_result, output calib_error);
  modport drive (input trim_result, input calib_error);
endinterface
`default_nettype wire

// ---- calib_result_store.sv ----
// holds the antenna calibration result and error flag
`timescale 1ns/1ns
`default_nettype none
module calib_result_store (
  input  wire logic                             core_clk,    // system clock
  input  wire logic                             reset,       // sync reset
  input  wire logic                             set_default, // restore pulse
  input  wire logic                             calib_done,  // command end
  input  wire logic [tune_regs_pkg::TRIM_W-1:0] calib_trim,  // engine trim
  input  wire logic                             calib_fail,  // no resonance
  calib_link_if.store                           link         // stored result
);
  logic [tune_regs_pkg::TRIM_W-1:0] trim_result;
  logic                             calib_error;

  // a completion in the restore cycle is kept; result and flag move together
  always_ff @(posedge core_clk) begin
    if (reset) begin
      trim_result <= tune_regs_pkg::TRIM_RESET;
      calib_error <= 1'b0;
    end else if (calib_done) begin
      trim_result <= calib_trim;
      calib_error <= calib_fail;
    end else if (set_default) begin
      trim_result <= tune_regs_pkg::TRIM_RESET;
      calib_error <= 1'b0;
    end
  end

  assign link.trim_result = trim_result;
  assign link.calib_error = calib_error;
endmodule
`default_nettype wire

// ---- tune_switch_drive.sv ----
// selects the source of the antenna tuning switches and drives both banks
`timescale 1ns/1ns
`default_nettype none
module tune_switch_drive (
  input  wire logic                             core_clk,     // system clock
  input  wire logic                             reset,        // sync reset
  input  wire logic                             set_default,  // restore pulse
  input  wire logic                             manual_src,   // 1: manual
  input  wire logic [tune_regs_pkg::TRIM_W-1:0] manual_trim,  // manual bits
  calib_link_if.drive                           link,         // auto result
  output logic      [tune_regs_pkg::TRIM_W-1:0] bank_one,     // bank one pins
  output logic      [tune_regs_pkg::TRIM_W-1:0] bank_two      // bank two pins
);
  logic [tune_regs_pkg::TRIM_W-1:0] next_trim;

  always_comb begin
    if (manual_src == tune_regs_pkg::SOURCE_MANUAL)
      next_trim = manual_trim;
    else
      next_trim = link.trim_result;
  end

  // a 1 turns the matching transistor on, same pattern on both banks
  always_ff @(posedge core_clk) begin
    if (reset || set_default) begin
      bank_one <= tune_regs_pkg::TRIM_RESET;
      bank_two <= tune_regs_pkg::TRIM_RESET;
    end else begin
      bank_one <= next_trim;
      bank_two <= next_trim;
    end
  end
endmodule
`default_nettype wire

// ---- antenna_tune_and_display_regs.sv ----
// register group for speed, converter and antenna tuning displays
`timescale 1ns/1ns
`default_nettype none
// Function
// - detected speed held in display bits 7..4
// - display registers clear at reset, and at restore unless a new result arrives in that cycle
// - converter register shows last conversion result
// - source bit picks automatic or manual tuning
// - manual bit set turns switch on, both banks
// - writable target phase, resets with bit 7
// - calibration result in bits 7..4 drives switches
// - calibration error flag in bit 3
// - wake-up-all with split bits, in bit-oriented framing with card idle, raises parity interrupt
module antenna_tune_and_display_regs #(
  parameter int unsigned TRIM_W = tune_regs_pkg::TRIM_W
) (
  input  wire logic                              core_clk,        // clock
  input  wire logic                              reset,           // sync reset
  input  wire logic                              set_default,     // restore
  input  wire logic [tune_regs_pkg::ADDR_W-1:0]  reg_addr,        // address
  input  wire logic [tune_regs_pkg::DATA_W-1:0]  reg_wdata,       // write data
  input  wire logic                              reg_write,       // write strb
  input  wire logic                              reg_read,        // read strb
  output logic      [tune_regs_pkg::DATA_W-1:0]  reg_rdata,       // read data
  output logic                                   reg_rvalid,      // read done
  input  wire logic                              speed_done,      // detect end
  input  wire logic [tune_regs_pkg::SPEED_W-1:0] speed_result,    // speed code
  input  wire logic                              adc_done,        // conv end
  input  wire logic [tune_regs_pkg::DATA_W-1:0]  adc_result,      // conv data
  input  wire logic                              calib_done,      // calib end
  input  wire logic [tune_regs_pkg::TRIM_W-1:0]  calib_trim,      // calib trim
  input  wire logic                              calib_fail,      // calib fail
  input  wire logic                              anticoll_on,     // framing opt
  input  wire logic                              card_idle,       // card idle
  input  wire logic [tune_regs_pkg::SPLIT_W-1:0] split_bits,      // split cnt
  input  wire logic                              wake_all_cmd,    // wake cmd
  output logic                                   parity_err_irq,  // irq pulse
  output logic      [tune_regs_pkg::DATA_W-1:0]  target_phase,    // phase tgt
  output logic                                   manual_source,   // src bit
  output logic      [tune_regs_pkg::TRIM_W-1:0]  tune_pin_bank_one, // bank 1
  output logic      [tune_regs_pkg::TRIM_W-1:0]  tune_pin_bank_two  // bank 2
);
  if (TRIM_W != tune_regs_pkg::TRIM_W) begin : g_trim_check
    $error("TRIM_W must match the four tuning switches");
  end

  calib_link_if calib_link ();

  logic [tune_regs_pkg::SPEED_W-1:0] detected_link_speed;
  logic [tune_regs_pkg::DATA_W-1:0]  converter_result;
  logic [TRIM_W-1:0]                 manual_trim;
  logic [tune_regs_pkg::DATA_W-1:0]  next_rdata;
  logic                              restore;

  assign restore = reset || set_default;

  function automatic logic is_write_to(
    input logic [tune_regs_pkg::ADDR_W-1:0] addr,
    input logic [tune_regs_pkg::ADDR_W-1:0] target,
    input logic                             strobe
  );
    is_write_to = strobe && (addr == target);
  endfunction

  // detected link speed; a new result in the restore cycle is kept
  always_ff @(posedge core_clk) begin
    if (reset)
      detected_link_speed <= tune_regs_pkg::SPEED_RESET;
    else if (speed_done)
      detected_link_speed <= speed_result;
    else if (set_default)
      detected_link_speed <= tune_regs_pkg::SPEED_RESET;
  end

  // last completed conversion
  always_ff @(posedge core_clk) begin
    if (reset)
      converter_result <= tune_regs_pkg::DISPLAY_RESET;
    else if (adc_done)
      converter_result <= adc_result;
    else if (set_default)
      converter_result <= tune_regs_pkg::DISPLAY_RESET;
  end

  // tuning control: source bit and manual bits
  always_ff @(posedge core_clk) begin
    if (restore) begin
      manual_source <= tune_regs_pkg::SOURCE_AUTO;
      manual_trim   <= tune_regs_pkg::TRIM_RESET;
    end else if (is_write_to(reg_addr, tune_regs_pkg::TUNE_CONTROL_ADDR,
                             reg_write)) begin
      manual_source <= reg_wdata[tune_regs_pkg::SOURCE_BIT];
      manual_trim   <= reg_wdata[tune_regs_pkg::MANUAL_LSB +: TRIM_W];
    end
  end

  // calibration target phase
  always_ff @(posedge core_clk) begin
    if (restore)
      target_phase <= tune_regs_pkg::TARGET_PHASE_RESET;
    else if (is_write_to(reg_addr, tune_regs_pkg::TARGET_PHASE_ADDR,
                         reg_write))
      target_phase <= reg_wdata;
  end

  calib_result_store u_calib_store (
    .core_clk    (core_clk),
    .reset       (reset),
    .set_default (set_default),
    .calib_done  (calib_done),
    .calib_trim  (calib_trim),
    .calib_fail  (calib_fail),
    .link        (calib_link)
  );

  tune_switch_drive u_switch_drive (
    .core_clk    (core_clk),
    .reset       (reset),
    .set_default (set_default),
    .manual_src  (manual_source),
    .manual_trim (manual_trim),
    .link        (calib_link),
    .bank_one    (tune_pin_bank_one),
    .bank_two    (tune_pin_bank_two)
  );

  // read mux; unused bits and unmapped addresses read zero
  always_comb begin
    next_rdata = tune_regs_pkg::DISPLAY_RESET;
    case (reg_addr)
      tune_regs_pkg::SPEED_DISPLAY_ADDR:
        next_rdata[tune_regs_pkg::SPEED_LSB +: tune_regs_pkg::SPEED_W] =
          detected_link_speed;
      tune_regs_pkg::CONVERTER_OUT_ADDR:
        next_rdata = converter_result;
      tune_regs_pkg::TUNE_CONTROL_ADDR: begin
        next_rdata[tune_regs_pkg::SOURCE_BIT] = manual_source;
        next_rdata[tune_regs_pkg::MANUAL_LSB +: TRIM_W] = manual_trim;
      end
      tune_regs_pkg::TARGET_PHASE_ADDR:
        next_rdata = target_phase;
      tune_regs_pkg::RESULT_DISPLAY_ADDR: begin
        next_rdata[tune_regs_pkg::RESULT_LSB +: TRIM_W] =
          calib_link.trim_result;
        next_rdata[tune_regs_pkg::CALIB_ERR_BIT] =
          calib_link.calib_error;
      end
      default:
        next_rdata = tune_regs_pkg::DISPLAY_RESET;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      reg_rdata  <= tune_regs_pkg::DISPLAY_RESET;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_read;
      if (reg_read)
        reg_rdata <= next_rdata;
    end
  end

  // wake-up-all to an idle card in bit-oriented framing with a split byte flags parity
  always_ff @(posedge core_clk) begin
    if (restore)
      parity_err_irq <= 1'b0;
    else
      parity_err_irq <= wake_all_cmd && anticoll_on && card_idle &&
                        (split_bits != tune_regs_pkg::NO_SPLIT_BITS);
  end
endmodule
`default_nettype wire

// ---- tune_regs_checker.sv ----
// assertions on the ports of the antenna tuning register group
`timescale 1ns/1ns
`default_nettype none
module tune_regs_checker #(
  parameter int unsigned TRIM_W = 4
) (
  input wire logic              core_clk,          // clock
  input wire logic              reset,             // sync reset
  input wire logic              set_default,       // restore
  input wire logic [5:0]        reg_addr,          // address
  input wire logic [7:0]        reg_wdata,         // write data
  input wire logic              reg_write,         // write strobe
  input wire logic              reg_read,          // read strobe
  input wire logic              reg_rvalid,        // read done
  input wire logic              calib_done,        // calib end
  input wire logic [3:0]        calib_trim,        // calib trim
  input wire logic              anticoll_on,       // framing option
  input wire logic              card_idle,         // card idle
  input wire logic [2:0]        split_bits,        // split count
  input wire logic              wake_all_cmd,      // wake command
  input wire logic              parity_err_irq,    // irq pulse
  input wire logic [7:0]        target_phase,      // phase target
  input wire logic              manual_source,     // source bit
  input wire logic [TRIM_W-1:0] tune_pin_bank_one, // bank one
  input wire logic [TRIM_W-1:0] tune_pin_bank_two  // bank two
);
  logic       cond;
  logic [3:0] mbits;
  assign cond = wake_all_cmd && anticoll_on && card_idle && split_bits != 3'h0;
  assign mbits = reg_wdata[6:3];
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  a_read_answer: assert property (reg_read |=> reg_rvalid)
    else $error("read strobe got no answer");
  a_banks_same: assert property (tune_pin_bank_one == tune_pin_bank_two)
    else $error("tuning banks differ");
  a_manual_follow: assert property ((reg_write && reg_addr == 6'h21 &&
    reg_wdata[7] && !set_default ##1 !set_default) |=>
    tune_pin_bank_one == $past(mbits, 2)) else $error("manual bits not driven");
  a_auto_follow: assert property ((calib_done ##1 (!manual_source &&
    !set_default && !calib_done)) |=> tune_pin_bank_one == $past(calib_trim, 2))
    else $error("calibration result not driven");
  a_phase_write: assert property ((reg_write && reg_addr == 6'h22 &&
    !set_default) |=> target_phase == $past(reg_wdata)) else $error("phase lost");
  a_phase_restore: assert property (set_default |=> target_phase == 8'h80)
    else $error("phase not restored");
  a_restore_banks: assert property (set_default |=>
    !manual_source && tune_pin_bank_one == 4'h0) else $error("tune not restored");
  a_parity_raise: assert property (cond && !set_default |=> parity_err_irq)
    else $error("parity pulse missing");
  a_parity_cause: assert property (parity_err_irq |-> $past(cond))
    else $error("parity pulse without cause");
  c_manual: cover property (manual_source && tune_pin_bank_one != 4'h0);
  c_parity: cover property (parity_err_irq);
  c_restore: cover property (set_default);
endmodule
bind antenna_tune_and_display_regs tune_regs_checker #(.TRIM_W(TRIM_W))
  i_tune_regs_checker (.*);
`default_nettype wire

// ---- tune_host.sv ----
// host model driving the register strobes on the falling clock edge
`timescale 1ns/1ns
`default_nettype none
module tune_host (
  input  wire logic       core_clk,   // clock
  input  wire logic [7:0] reg_rdata,  // read data
  input  wire logic       reg_rvalid, // read done
  output logic      [5:0] reg_addr,   // address
  output logic      [7:0] reg_wdata,  // write data
  output logic            reg_write,  // write strobe
  output logic            reg_read    // read strobe
);
  initial begin
    {reg_addr, reg_wdata, reg_write, reg_read} = 16'h0000;
  end
  // released address and data show the inverse, never the old value
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge core_clk);
    {reg_addr, reg_wdata, reg_write} = {a, d, 1'b1};
    @(negedge core_clk);
    {reg_addr, reg_wdata, reg_write} = {~a, ~d, 1'b0};
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(negedge core_clk);
    {reg_addr, reg_read} = {a, 1'b1};
    @(negedge core_clk);
    {reg_addr, reg_read} = {~a, 1'b0};
    // answer is due one cycle after the strobe; a missing one reads unknown
    d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
  endtask
endmodule
`default_nettype wire

// ---- antenna_tune_and_display_regs_tb.sv ----
// self-checking bench for the antenna tuning register group
`timescale 1ns/1ns
`default_nettype none
module antenna_tune_and_display_regs_tb;
  typedef struct packed {
    logic [5:0] a;
    logic       w;
    logic [7:0] d;
    logic [7:0] e;
  } row_s;
  localparam row_s ROWS [13] = '{
    '{6'h1f, 1'b0, 8'h00, 8'h00}, '{6'h20, 1'b0, 8'h00, 8'h00},
    '{6'h21, 1'b0, 8'h00, 8'h00}, '{6'h22, 1'b0, 8'h00, 8'h80},
    '{6'h23, 1'b0, 8'h00, 8'h00}, '{6'h3f, 1'b0, 8'h00, 8'h00},
    '{6'h21, 1'b1, 8'hff, 8'hf8}, '{6'h22, 1'b1, 8'h5a, 8'h5a},
    '{6'h1f, 1'b1, 8'hff, 8'h00}, '{6'h20, 1'b1, 8'hff, 8'h00},
    '{6'h23, 1'b1, 8'hff, 8'h00}, '{6'h3f, 1'b1, 8'hff, 8'h00},
    '{6'h21, 1'b1, 8'h00, 8'h00}};
  logic       core_clk, reset, set_default, reg_write, reg_read, reg_rvalid;
  logic       speed_done, adc_done, calib_done, calib_fail, parity_err_irq;
  logic       anticoll_on, card_idle, wake_all_cmd, manual_source;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, adc_result, target_phase;
  logic [3:0] speed_result, calib_trim, tune_pin_bank_one, tune_pin_bank_two;
  logic [2:0] split_bits;
  int         failures, total_checks, cycles;
  antenna_tune_and_display_regs i_antenna_tune_and_display_regs (.*);
  tune_host i_tune_host (.*);
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic summarize;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      summarize();
    end
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rdchk(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] v;
    i_tune_host.rd(a, v);
    chk($sformatf("reg %h", a), e, v);
  endtask
  task automatic banks(input logic [3:0] e);
    chk("bank one", {4'h0, e}, {4'h0, tune_pin_bank_one});
    chk("bank two", {4'h0, e}, {4'h0, tune_pin_bank_two});
  endtask
  initial begin
    {set_default, speed_done, adc_done, calib_done, wake_all_cmd} = 5'h00;
    {anticoll_on, card_idle, split_bits, reset, calib_fail} = 7'h63;
    {speed_result, adc_result, calib_trim} = 16'ha3c5;
    repeat (2) @(negedge core_clk);
    reset = 1'b0;
    foreach (ROWS[i]) begin
      if (ROWS[i].w) i_tune_host.wr(ROWS[i].a, ROWS[i].d);
      rdchk(ROWS[i].a, ROWS[i].e);
    end
    chk("phase port", 8'h5a, target_phase);
    {speed_done, adc_done, calib_done} = 3'h7;
    @(negedge core_clk);
    {speed_done, adc_done, calib_done} = 3'h0;
    @(negedge core_clk);
    banks(4'h5);
    rdchk(6'h1f, 8'ha0);
    rdchk(6'h20, 8'h3c);
    rdchk(6'h23, 8'h58);
    i_tune_host.wr(6'h21, 8'hc8);
    @(negedge core_clk);
    banks(4'h9);
    set_default = 1'b1;
    @(negedge core_clk);
    set_default = 1'b0;
    banks(4'h0);
    rdchk(6'h1f, 8'h00);
    rdchk(6'h20, 8'h00);
    rdchk(6'h23, 8'h00);
    rdchk(6'h22, 8'h80);
    {wake_all_cmd, split_bits} = 4'h9;
    @(negedge core_clk);
    wake_all_cmd = 1'b0;
    chk("parity", 8'h01, {7'h00, parity_err_irq});
    {wake_all_cmd, split_bits} = 4'h8;
    @(negedge core_clk);
    wake_all_cmd = 1'b0;
    chk("parity", 8'h00, {7'h00, parity_err_irq});
    @(negedge core_clk);
    chk("parity", 8'h00, {7'h00, parity_err_irq});
    {wake_all_cmd, split_bits, card_idle} = 5'h12;
    @(negedge core_clk);
    {wake_all_cmd, card_idle, anticoll_on} = 3'h6;
    chk("parity idle", 8'h00, {7'h00, parity_err_irq});
    @(negedge core_clk);
    {wake_all_cmd, anticoll_on} = 2'h1;
    chk("parity framing", 8'h00, {7'h00, parity_err_irq});
    // completion in the restore cycle is kept, with a clean error flag
    {calib_done, set_default, calib_fail, calib_trim} = 7'h63;
    @(negedge core_clk);
    {calib_done, set_default} = 2'h0;
    @(negedge core_clk);
    banks(4'h3);
    rdchk(6'h23, 8'h30);
    i_tune_host.wr(6'h21, 8'hb0);
    i_tune_host.wr(6'h22, 8'h11);
    banks(4'h6);
    chk("phase port", 8'h11, target_phase);
    chk("source port", 8'h01, {7'h00, manual_source});
    reset = 1'b1;
    @(negedge core_clk);
    reset = 1'b0;
    chk("read data", 8'h00, reg_rdata);
    chk("phase port", 8'h80, target_phase);
    chk("source port", 8'h00, {7'h00, manual_source});
    banks(4'h0);
    rdchk(6'h23, 8'h00);
    rdchk(6'h21, 8'h00);
    summarize();
  end
endmodule
`default_nettype wire
